// [pkg/slc_pkg.sv]
// Package for the primary loop control block: register map, codes and timing
package slc_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_BW = 12'h004;
  localparam logic [11:0] ADDR_HOLD_CFG = 12'h008;
  localparam logic [11:0] ADDR_OFS_LO = 12'h00c;
  localparam logic [11:0] ADDR_OFS_HI = 12'h010;
  localparam logic [11:0] ADDR_SLOPE = 12'h014;
  localparam logic [11:0] ADDR_LIMIT = 12'h018;
  localparam logic [11:0] ADDR_STATUS = 12'h01c;
  localparam logic [11:0] ADDR_APPLIED = 12'h020;
  localparam logic [11:0] ADDR_FREQ_LO = 12'h024;
  localparam logic [11:0] ADDR_PBO = 12'h028;

  // Operating mode codes
  localparam logic [4:0] MODE_AUTO = 5'h00;
  localparam logic [4:0] MODE_FREERUN = 5'h01;
  localparam logic [4:0] MODE_HOLDOVER = 5'h02;
  localparam logic [4:0] MODE_LOCKED = 5'h04;
  localparam logic [4:0] MODE_PRELOCK2 = 5'h05;
  localparam logic [4:0] MODE_PRELOCK = 5'h06;
  localparam logic [4:0] MODE_LOSTPH = 5'h07;
  localparam logic [4:0] MODE_DCO = 5'h0a;

  localparam logic [4:0] BW_CODE_MAX = 5'h15;
  localparam logic [2:0] SLOPE_PROG = 3'h7;
  localparam logic [2:0] SLOPE_RESET = 3'h7;
  localparam logic [1:0] HIST_RESET = 2'h0;
  localparam logic [1:0] AVG_RESET = 2'h1;

  // Hold config and PBO bit positions
  localparam int HC_AVG_LSB = 0;
  localparam int HC_HIST_LSB = 2;
  localparam int HC_AUTO = 4;
  localparam int HC_MAN = 5;
  localparam int HC_RDAVG = 6;
  localparam int PBO_EN = 0;
  localparam int PBO_FRZ = 1;

  // Timing
  localparam longint CLK_HZ = 20000000;
  localparam int START_TIME_S = 2;
  localparam longint START_CYC = CLK_HZ * START_TIME_S;
  localparam int HIST1_S = 1;
  localparam int HIST8_S = 8;
  localparam int HIST64_S = 64;

  typedef enum logic [2:0] {
    STG_START = 3'b001,
    STG_ACQ = 3'b010,
    STG_LOCK = 3'b100
  } slc_stage_t;

  typedef struct packed {
    logic [4:0] bw;
    logic [2:0] damp;
  } slc_loop_set_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } slc_apb_req_t;
endpackage

// [src/slc_loop_ctrl.sv]
// Primary loop control: stage bandwidth, DCO, holdover, hitless switch, slope and limit
// Behaviour
// - First two seconds of a lock attempt use starting bandwidth and damping.
// - Acquisition stage uses acquisition bandwidth and damping.
// - Once locked, use locked bandwidth and damping.
// - Stages advance automatically with the matching set, no software action.
// - Locked bandwidth codes 0 to 21 valid; 22 to 31 reserved.
// - Locked mode follows phase and frequency of selected input.
// - Pre-locked2 and lost-phase still track the selected input.
// - Host writes 40-bit signed offset; oscillator runs at it within 92 ppm.
// - Mode code 01010 drives output from the written offset word.
// - Offset word LSB is a fixed fine step, not scaled by applied offset.
// - Holdover steers from stored frequency, no phase lock.
// - Without manual or auto averaging, history field picks averaged value.
// - History picks now, 1, 8 or 64 s; averaging picks filter bandwidth.
// - Manual holdover takes offset straight from the written word.
// - Reset defaults to current averaged value, 1.5 mHz filter.
// - Offset word reads averaged value if read-average set, else written.
// - Hitless enabled: reference change or holdover exit triggers phase build-out.
// - Freeze ignores new triggers and holds compensated phase offset.
// - Hitless disabled: phase slews back to zero under slope limit.
// - Three-bit slope code picks fixed limits; 111 picks programmable.
// - Programmable slope is 24 bits, resets to zero.
// - Output frequency always clamped within the hard offset limit.
`timescale 1ns/1ns
module slc_loop_ctrl #(
  parameter longint START_CYCLES = slc_pkg::START_CYC,
  parameter longint SEC_CYCLES = slc_pkg::CLK_HZ,
  parameter int FW = 40
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire slc_pkg::slc_apb_req_t APB_REQ,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] PRDATA,
  input wire logic REF_VALID,
  input wire logic REF_SWITCH,
  input wire logic LOOP_LOCKED,
  input wire logic [FW-1:0] LOOP_FREQ,
  input wire logic [31:0] PHASE_ERR,
  output slc_pkg::slc_loop_set_t LOOP_SET,
  output logic TRACK_PHASE,
  output logic TRACK_FREQ,
  output logic [FW-1:0] FREQ_OUT,
  output logic [31:0] PHASE_COMP,
  output logic [2:0] SLOPE_CODE,
  output logic [23:0] SLOPE_VALUE,
  output logic PBO_EVENT
);
  import slc_pkg::*;

  // ****************************************
  // Reset and bus
  // ****************************************
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  logic wr_en, rd_en, addr_ok;
  assign wr_en = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign rd_en = APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite;
  assign PREADY = 1'b1;
  always_comb begin
    case (APB_REQ.paddr)
      ADDR_MODE, ADDR_BW, ADDR_HOLD_CFG, ADDR_OFS_LO, ADDR_OFS_HI, ADDR_SLOPE,
      ADDR_LIMIT, ADDR_STATUS, ADDR_APPLIED, ADDR_FREQ_LO, ADDR_PBO: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign PSLVERR = APB_REQ.psel && APB_REQ.penable && !addr_ok;

  function automatic logic wr_hit(input logic [11:0] a);
    wr_hit = wr_en && (APB_REQ.paddr == a);
  endfunction

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [4:0] loop_mode_select_r;
  slc_loop_set_t start_set_r, acquire_set_r, lock_set_r;
  logic [1:0] avg_r, hist_r;
  logic auto_r, man_r, rdavg_r;
  logic [FW-1:0] offset_word_r, limit_r;
  logic [2:0] slope_limit_code_r;
  logic [23:0] slope_limit_value_r;
  logic hs_en_r, hs_frz_r;

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      loop_mode_select_r <= MODE_AUTO;
      start_set_r <= '0;
      acquire_set_r <= '0;
      lock_set_r <= '0;
      avg_r <= AVG_RESET;
      hist_r <= HIST_RESET;
      auto_r <= 1'b0;
      man_r <= 1'b0;
      rdavg_r <= 1'b0;
      slope_limit_code_r <= SLOPE_RESET;
      slope_limit_value_r <= '0;
      limit_r <= '1;
      hs_en_r <= 1'b0;
      hs_frz_r <= 1'b0;
    end else begin
      if (wr_hit(ADDR_MODE)) loop_mode_select_r <= APB_REQ.pwdata[4:0];
      if (wr_hit(ADDR_BW)) begin
        start_set_r <= APB_REQ.pwdata[7:0];
        acquire_set_r <= APB_REQ.pwdata[15:8];
        // reserved locked codes are refused, old value kept
        if (APB_REQ.pwdata[23:19] <= BW_CODE_MAX) lock_set_r <= APB_REQ.pwdata[23:16];
      end
      if (wr_hit(ADDR_HOLD_CFG)) begin
        avg_r <= APB_REQ.pwdata[HC_AVG_LSB+:2];
        hist_r <= APB_REQ.pwdata[HC_HIST_LSB+:2];
        auto_r <= APB_REQ.pwdata[HC_AUTO];
        man_r <= APB_REQ.pwdata[HC_MAN];
        rdavg_r <= APB_REQ.pwdata[HC_RDAVG];
      end
      if (wr_hit(ADDR_SLOPE)) begin
        slope_limit_code_r <= APB_REQ.pwdata[26:24];
        slope_limit_value_r <= APB_REQ.pwdata[23:0];
      end
      if (wr_hit(ADDR_LIMIT)) limit_r <= {APB_REQ.pwdata[FW-9:0], 8'hff};
      if (wr_hit(ADDR_PBO)) begin
        hs_en_r <= APB_REQ.pwdata[PBO_EN];
        hs_frz_r <= APB_REQ.pwdata[PBO_FRZ];
      end
    end
  end

  // offset word written as low and high halves, each on its own, in either order
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      offset_word_r <= '0;
    end else begin
      if (wr_hit(ADDR_OFS_LO)) offset_word_r[31:0] <= APB_REQ.pwdata;
      if (wr_hit(ADDR_OFS_HI)) offset_word_r[FW-1:32] <= APB_REQ.pwdata[FW-33:0];
    end
  end

  // ****************************************
  // Locking stages
  // ****************************************
  slc_stage_t stage_r, stage_nxt;
  logic [31:0] stage_cnt_r;
  logic tracking;
  assign tracking = (loop_mode_select_r == MODE_LOCKED) ||
    (loop_mode_select_r == MODE_PRELOCK2) || (loop_mode_select_r == MODE_PRELOCK) ||
    (loop_mode_select_r == MODE_LOSTPH) ||
    ((loop_mode_select_r == MODE_AUTO) && REF_VALID);

  always_comb begin
    stage_nxt = stage_r;
    case (stage_r)
      STG_START: if (stage_cnt_r >= 32'(START_CYCLES - 1)) stage_nxt = STG_ACQ;
      STG_ACQ: if (LOOP_LOCKED) stage_nxt = STG_LOCK;
      STG_LOCK: if (!LOOP_LOCKED) stage_nxt = STG_ACQ;
      default: stage_nxt = STG_START;
    endcase
    if (!tracking || REF_SWITCH) stage_nxt = STG_START;
  end

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stage_r <= STG_START;
      stage_cnt_r <= '0;
    end else begin
      stage_r <= stage_nxt;
      stage_cnt_r <= (stage_nxt == STG_START && stage_r == STG_START && tracking &&
        !REF_SWITCH) ? stage_cnt_r + 32'h1 : 32'h0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      LOOP_SET <= '0;
    end else begin
      case (stage_r)
        STG_ACQ: LOOP_SET <= acquire_set_r;
        STG_LOCK: LOOP_SET <= lock_set_r;
        default: LOOP_SET <= start_set_r;
      endcase
    end
  end

  // ****************************************
  // Holdover averaging and history
  // ****************************************
  logic [FW-1:0] avg_now_r, hist1_r, hist8_r, hist64_r, hold_val_r;
  logic [31:0] sec_cnt_r;
  logic [6:0] sec_num_r;
  logic locked_now, sec_tick;
  assign locked_now = tracking && stage_r == STG_LOCK;
  assign sec_tick = sec_cnt_r >= 32'(SEC_CYCLES - 1);

  function automatic logic [5:0] avg_shift(input logic [1:0] m);
    case (m)
      2'h0: avg_shift = 6'h10;
      2'h1: avg_shift = 6'h0d;
      2'h2: avg_shift = 6'h0a;
      default: avg_shift = 6'h06;
    endcase
  endfunction

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avg_now_r <= '0;
    end else if (locked_now) begin
      avg_now_r <= avg_now_r + FW'(($signed(LOOP_FREQ) - $signed(avg_now_r)) >>>
        avg_shift(avg_r));
    end
  end

  // history snapshots at 1, 8 and 64 s
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sec_cnt_r <= '0;
      sec_num_r <= '0;
      hist1_r <= '0;
      hist8_r <= '0;
      hist64_r <= '0;
    end else if (locked_now) begin
      sec_cnt_r <= sec_tick ? 32'h0 : sec_cnt_r + 32'h1;
      if (sec_tick) begin
        sec_num_r <= sec_num_r + 7'h1;
        hist1_r <= avg_now_r;
        if (sec_num_r % 7'(HIST8_S) == 7'h0) hist8_r <= avg_now_r;
        if (sec_num_r % 7'(HIST64_S) == 7'h0) hist64_r <= avg_now_r;
      end
    end
  end

  logic [FW-1:0] hold_sel;
  always_comb begin
    if (man_r) hold_sel = offset_word_r;
    else if (auto_r) hold_sel = avg_now_r;
    else begin
      case (hist_r)
        2'h1: hold_sel = hist1_r;
        2'h2: hold_sel = hist8_r;
        2'h3: hold_sel = hist64_r;
        default: hold_sel = avg_now_r;
      endcase
    end
  end

  logic was_hold_r;
  logic in_hold;
  assign in_hold = loop_mode_select_r == MODE_HOLDOVER;
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) hold_val_r <= '0;
    else if (!in_hold || man_r) hold_val_r <= hold_sel;
  end

  // ****************************************
  // Frequency output and clamp
  // ****************************************
  // Limit is a magnitude; top bit set saturates to the full positive range
  function automatic logic [FW-1:0] lim_mag(input logic [FW-1:0] l);
    lim_mag = l[FW-1] ? {1'b0, {(FW-1){1'b1}}} : l;
  endfunction

  function automatic logic [FW-1:0] clamp(input logic [FW-1:0] v, input logic [FW-1:0] l);
    logic [FW-1:0] pl;
    logic [FW-1:0] nl;
    pl = lim_mag(l);
    nl = -pl;
    if ($signed(v) > $signed(pl)) clamp = pl;
    else if ($signed(v) < $signed(nl)) clamp = nl;
    else clamp = v;
  endfunction

  logic [FW-1:0] freq_raw;
  always_comb begin
    // DCO step is the offset LSB
    if (loop_mode_select_r == MODE_DCO) freq_raw = offset_word_r;
    else if (in_hold) freq_raw = hold_val_r;
    else if (tracking) freq_raw = LOOP_FREQ;
    else freq_raw = '0;
  end

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) FREQ_OUT <= '0;
    else FREQ_OUT <= clamp(freq_raw, limit_r);
  end

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      TRACK_PHASE <= 1'b0;
      TRACK_FREQ <= 1'b0;
    end else begin
      TRACK_PHASE <= tracking;
      TRACK_FREQ <= tracking;
    end
  end

  // ****************************************
  // Hitless switching
  // ****************************************
  logic hs_trig;
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) was_hold_r <= 1'b0;
    else was_hold_r <= in_hold || loop_mode_select_r == MODE_FREERUN;
  end
  // trigger on switch or holdover/free-run exit
  assign hs_trig = hs_en_r && !hs_frz_r &&
    (REF_SWITCH || (was_hold_r && tracking));

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      PHASE_COMP <= '0;
      PBO_EVENT <= 1'b0;
    end else begin
      PBO_EVENT <= hs_trig;
      if (hs_trig) PHASE_COMP <= PHASE_ERR;
      // decay toward zero, slope limit applied downstream
      else if (!hs_en_r && PHASE_COMP != 32'h0)
        PHASE_COMP <= PHASE_COMP - {{31{PHASE_COMP[31]}}, 1'b1};
    end
  end
  assign SLOPE_CODE = slope_limit_code_r;
  assign SLOPE_VALUE = slope_limit_value_r;

  // ****************************************
  // Read path
  // ****************************************
  logic [FW-1:0] ofs_rd;
  assign ofs_rd = rdavg_r ? hold_sel : offset_word_r;
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) PRDATA <= '0;
    else if (APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite) begin
      case (APB_REQ.paddr)
        ADDR_MODE: PRDATA <= {27'h0, loop_mode_select_r};
        ADDR_BW: PRDATA <= {8'h0, lock_set_r, acquire_set_r, start_set_r};
        ADDR_HOLD_CFG: PRDATA <= {25'h0, rdavg_r, man_r, auto_r, hist_r, avg_r};
        ADDR_OFS_LO: PRDATA <= ofs_rd[31:0];
        ADDR_OFS_HI: PRDATA <= {24'h0, ofs_rd[FW-1:32]};
        ADDR_SLOPE: PRDATA <= {5'h0, slope_limit_code_r, slope_limit_value_r};
        ADDR_LIMIT: PRDATA <= limit_r[FW-1:8];
        ADDR_STATUS: PRDATA <= {29'h0, stage_r};
        ADDR_APPLIED: PRDATA <= {24'h0, LOOP_SET};
        ADDR_FREQ_LO: PRDATA <= FREQ_OUT[31:0];
        ADDR_PBO: PRDATA <= {30'h0, hs_frz_r, hs_en_r};
        default: PRDATA <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_start_set: assert property (@(posedge CLK) disable iff (!rst_n_r)
    stage_r == STG_START |=> LOOP_SET == $past(start_set_r)) else $error("start set");
  chk_lock_set: assert property (@(posedge CLK) disable iff (!rst_n_r)
    stage_r == STG_LOCK |=> LOOP_SET == $past(lock_set_r)) else $error("lock set");
  chk_acq_set: assert property (@(posedge CLK) disable iff (!rst_n_r)
    stage_r == STG_ACQ |=> LOOP_SET == $past(acquire_set_r)) else $error("acq set");
  chk_lock_enter: assert property (@(posedge CLK) disable iff (!rst_n_r)
    stage_r == STG_ACQ && LOOP_LOCKED && tracking && !REF_SWITCH |=> stage_r == STG_LOCK)
    else $error("no lock entry");
  chk_bw_legal: assert property (@(posedge CLK) disable iff (!rst_n_r)
    lock_set_r.bw <= BW_CODE_MAX) else $error("reserved bw");
  chk_dco_out: assert property (@(posedge CLK) disable iff (!rst_n_r)
    loop_mode_select_r == MODE_DCO
    |=> FREQ_OUT == clamp($past(offset_word_r), $past(limit_r))) else $error("dco freq");
  chk_clamp_hi: assert property (@(posedge CLK) disable iff (!rst_n_r)
    $signed(FREQ_OUT) <= $signed(lim_mag($past(limit_r)))) else $error("clamp");
  chk_freeze_hold: assert property (@(posedge CLK) disable iff (!rst_n_r)
    hs_frz_r && hs_en_r |=> PHASE_COMP == $past(PHASE_COMP)) else $error("freeze");
  chk_rd_avg: assert property (@(posedge CLK) disable iff (!rst_n_r)
    !rdavg_r |-> ofs_rd == offset_word_r) else $error("read sel");
  chk_man_hold: assert property (@(posedge CLK) disable iff (!rst_n_r)
    man_r |-> hold_sel == offset_word_r) else $error("manual");
  cov_lock: cover property (@(posedge CLK) stage_r == STG_ACQ ##1 stage_r == STG_LOCK);
  cov_pbo: cover property (@(posedge CLK) PBO_EVENT);
  cov_dco: cover property (@(posedge CLK) loop_mode_select_r == MODE_DCO);
endmodule

// [dv/slc_ref_model.sv]
// Behavioural model of the selected reference and its lock detector
`timescale 1ns/1ns
module slc_ref_model (
  input wire logic clk,
  input wire logic lock_cmd,
  input wire logic sw_cmd,
  input wire logic [39:0] freq_cmd,
  input wire logic [31:0] phase_cmd,
  output logic ref_valid,
  output logic ref_switch,
  output logic loop_locked,
  output logic [39:0] loop_freq,
  output logic [31:0] phase_err
);
  logic sw_d_r;

  initial begin
    ref_valid = 1'b0;
    ref_switch = 1'b0;
    loop_locked = 1'b0;
    loop_freq = '0;
    phase_err = '0;
    sw_d_r = 1'b0;
  end

  // Reference is always present; lock follows the bench's command
  always @(posedge clk) begin
    ref_valid <= 1'b1;
    loop_locked <= lock_cmd;
    loop_freq <= freq_cmd;
    phase_err <= phase_cmd;
    sw_d_r <= sw_cmd;
    // references here run at 8 kHz or more
    ref_switch <= sw_cmd & ~sw_d_r;
  end
endmodule

// [dv/tb_slc_loop_ctrl.sv]
// Self-checking testbench for the primary loop control block
`timescale 1ns/1ns
module tb_slc_loop_ctrl;
  import slc_pkg::*;
  // Short counts keep the stage timer within a few dozen cycles
  localparam longint START_N = 20;
  localparam longint SEC_N = 10;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  slc_apb_req_t apb_req = '0;
  logic pready, pslverr, track_phase, track_freq, pbo_event;
  logic [31:0] prdata, phase_comp, phase_err;
  slc_loop_set_t loop_set;
  logic [39:0] freq_out, loop_freq;
  logic [2:0] slope_code;
  logic [23:0] slope_value;
  logic ref_valid, ref_switch, loop_locked;
  logic lock_cmd = 1'b0;
  logic sw_cmd = 1'b0;
  logic [39:0] freq_cmd = '0;
  logic [31:0] phase_cmd = '0;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;

  slc_loop_ctrl #(.START_CYCLES(START_N), .SEC_CYCLES(SEC_N), .FW(40)) i_slc_loop_ctrl (
    .CLK(clk), .RESET_N(reset_n), .APB_REQ(apb_req), .PREADY(pready), .PSLVERR(pslverr),
    .PRDATA(prdata), .REF_VALID(ref_valid), .REF_SWITCH(ref_switch),
    .LOOP_LOCKED(loop_locked), .LOOP_FREQ(loop_freq), .PHASE_ERR(phase_err),
    .LOOP_SET(loop_set), .TRACK_PHASE(track_phase), .TRACK_FREQ(track_freq),
    .FREQ_OUT(freq_out), .PHASE_COMP(phase_comp), .SLOPE_CODE(slope_code),
    .SLOPE_VALUE(slope_value), .PBO_EVENT(pbo_event));

  slc_ref_model i_slc_ref_model (
    .clk(clk), .lock_cmd(lock_cmd), .sw_cmd(sw_cmd), .freq_cmd(freq_cmd),
    .phase_cmd(phase_cmd), .ref_valid(ref_valid), .ref_switch(ref_switch),
    .loop_locked(loop_locked), .loop_freq(loop_freq), .phase_err(phase_err));

  // ******************************
  // Helpers
  // ******************************
  initial forever #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic expect_eq(input logic [39:0] got, input logic [39:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic expect_true(input logic c, input string m);
    expect_eq({39'b0, c}, 40'h1, m);
  endtask

  // Setup cycle, then access until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    expect_true(n < 50, "apb answer");
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    expect_eq({8'h0, r}, {8'h0, exp}, m);
  endtask

  task automatic pulse_sw();
    @(posedge clk) sw_cmd <= 1'b1;
    @(posedge clk) sw_cmd <= 1'b0;
  endtask

  // ******************************
  // Scenarios
  // ******************************
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd_chk(ADDR_HOLD_CFG, 32'h0000_0001, "hold cfg reset");
    rd_chk(ADDR_SLOPE, 32'h0700_0000, "slope reset");
    rd_chk(ADDR_LIMIT, 32'hffff_ffff, "limit reset");
    apb(1'b0, 12'h0fc, 32'h0, r, e);
    expect_true(e === 1'b1 && r === 32'h0, "unmapped read");
  endtask

  task automatic t_stages();
    int t0;
    int n;
    wr(ADDR_BW, 32'h00ad_4311);
    wr(ADDR_MODE, {27'h0, MODE_LOCKED});
    pulse_sw();
    t0 = cyc;
    repeat (4) @(posedge clk);
    expect_eq(loop_set, 40'h11, "start set");
    rd_chk(ADDR_STATUS, 32'h1, "stage start");
    n = 0;
    while (loop_set !== 8'h43 && n < 200) begin
      @(posedge clk);
      n++;
    end
    expect_true(cyc - t0 >= START_N - 2 && cyc - t0 <= START_N + 6, "acq timing");
    rd_chk(ADDR_STATUS, 32'h2, "stage acq");
    lock_cmd <= 1'b1;
    n = 0;
    while (loop_set !== 8'had && n < 20) begin
      @(posedge clk);
      n++;
    end
    expect_true(n < 20, "lock set");
    rd_chk(ADDR_STATUS, 32'h4, "stage lock");
    rd_chk(ADDR_APPLIED, 32'h0000_00ad, "applied set");
    expect_true(track_phase === 1'b1 && track_freq === 1'b1, "locked tracks");
    // Reserved locked code 22 must not disturb the applied set
    wr(ADDR_BW, 32'h00b5_4311);
    rd_chk(ADDR_BW, 32'h00ad_4311, "reserved bw");
    expect_eq(loop_set, 40'had, "reserved bw set");
  endtask

  task automatic t_modes();
    wr(ADDR_MODE, {27'h0, MODE_PRELOCK2});
    repeat (3) @(posedge clk);
    expect_true(track_freq === 1'b1, "prelock2 tracks");
    wr(ADDR_MODE, {27'h0, MODE_LOSTPH});
    repeat (3) @(posedge clk);
    expect_true(track_freq === 1'b1, "lost phase tracks");
    wr(ADDR_MODE, {27'h0, MODE_HOLDOVER});
    repeat (3) @(posedge clk);
    expect_true(track_phase === 1'b0, "holdover no phase");
  endtask

  task automatic t_dco();
    // host writes the signed word in two halves
    wr(ADDR_OFS_LO, 32'h8765_4321);
    wr(ADDR_OFS_HI, 32'h0000_00ff);
    wr(ADDR_MODE, {27'h0, MODE_DCO});
    repeat (4) @(posedge clk);
    expect_eq(freq_out, 40'hff_8765_4321, "dco word");
    rd_chk(ADDR_FREQ_LO, 32'h8765_4321, "freq readback");
    wr(ADDR_LIMIT, 32'h0000_0100);
    repeat (4) @(posedge clk);
    expect_eq(freq_out, 40'hff_fffe_ff01, "neg clamp");
    wr(ADDR_OFS_HI, 32'h0000_0000);
    wr(ADDR_OFS_LO, 32'h1000_0000);
    repeat (4) @(posedge clk);
    expect_eq(freq_out, 40'h00_0001_00ff, "pos clamp");
    wr(ADDR_LIMIT, 32'hffff_ffff);
    wr(ADDR_OFS_LO, 32'h0000_0001);
    repeat (4) @(posedge clk);
    expect_eq(freq_out, 40'h1, "one step");
    rd_chk(ADDR_OFS_LO, 32'h0000_0001, "written readback");
  endtask

  task automatic t_hold();
    logic signed [39:0] d;
    logic [31:0] r;
    logic e;
    freq_cmd <= 40'h00_0000_4000;
    wr(ADDR_HOLD_CFG, 32'h0000_0003);
    wr(ADDR_MODE, {27'h0, MODE_LOCKED});
    repeat (3000) @(posedge clk);
    wr(ADDR_MODE, {27'h0, MODE_HOLDOVER});
    freq_cmd <= 40'h0;
    repeat (20) @(posedge clk);
    d = $signed(freq_out) - 40'sh4000;
    expect_true(d < 128 && d > -128, "holdover average");
    wr(ADDR_HOLD_CFG, 32'h0000_0043);
    apb(1'b0, ADDR_OFS_LO, 32'h0, r, e);
    expect_true(r > 32'h3f80 && r < 32'h4080, "avg readback");
    wr(ADDR_HOLD_CFG, 32'h0000_004b);
    apb(1'b0, ADDR_OFS_LO, 32'h0, r, e);
    expect_true(r > 32'h3f80 && r < 32'h4080, "8 s history readback");
    wr(ADDR_HOLD_CFG, 32'h0000_0020);
    wr(ADDR_OFS_LO, 32'h0000_0777);
    repeat (4) @(posedge clk);
    expect_eq(freq_out, 40'h777, "manual holdover");
  endtask

  task automatic t_hitless();
    int n;
    logic seen;
    wr(ADDR_MODE, {27'h0, MODE_LOCKED});
    phase_cmd <= 32'd1000;
    wr(ADDR_PBO, 32'h1);
    pulse_sw();
    seen = 1'b0;
    repeat (10) @(posedge clk) seen = seen | (pbo_event === 1'b1);
    expect_true(seen, "switch event");
    expect_eq({8'h0, phase_comp}, 40'd1000, "compensated phase");
    wr(ADDR_PBO, 32'h3);
    phase_cmd <= 32'd2000;
    pulse_sw();
    seen = 1'b0;
    repeat (10) @(posedge clk) seen = seen | (pbo_event === 1'b1);
    expect_true(!seen, "frozen event");
    expect_eq({8'h0, phase_comp}, 40'd1000, "frozen phase");
    wr(ADDR_PBO, 32'h0);
    repeat (100) @(posedge clk);
    expect_true(phase_comp < 32'd1000 && phase_comp > 32'd850, "slew rate");
    n = 0;
    while (phase_comp !== 32'd0 && n < 1200) begin
      @(posedge clk);
      n++;
    end
    expect_true(n < 1200, "slew to zero");
  endtask

  task automatic t_slope();
    logic [23:0] v;
    for (int i = 0; i < 8; i++) begin
      v = (i == 7) ? 24'hff_ffff : 24'h00_1000 + 24'(i);
      wr(ADDR_SLOPE, {5'h0, 3'(i), v});
      repeat (2) @(posedge clk);
      expect_eq({37'h0, slope_code}, 40'(i), "slope code");
      expect_eq({16'h0, slope_value}, {16'h0, v}, "slope value");
    end
  endtask

  // ******************************
  // Main sequence and watchdog
  // ******************************
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    expect_eq({37'h0, slope_code}, 40'h7, "slope code reset");
    t_reset();
    t_stages();
    t_modes();
    t_dco();
    t_hold();
    t_hitless();
    t_slope();
    conclude();
  end

  initial begin
    #(50 * 40000);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
